// ==== rtl/usfl_top.sv ====
// Serial port status flags, receiver, transmitter and Wishbone registers.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
`include "usfl_map.svh"
module usfl_top
(
    input wire logic clk,
    input wire logic reset,
    input wire usfl_pkg::usfl_wb_req_type wb_req,
    output usfl_pkg::usfl_wb_rsp_type wb_rsp,
    input wire logic rx_in,
    output logic tx_out,
    output logic tx_oe,
    output logic rx_irq
);
    import usfl_pkg::*;

    usfl_state_type st;
    usfl_state_type next_st;
    logic acc;
    logic rd;
    logic wr;
    logic data_acc;
    logic tick;
    logic word_done;
    logic pop;
    logic head_load;
    logic bitval;
    logic [3:0] nbits;
    logic [8:0] rx_word;
    logic [8:0] tx_word;
    logic tx_par;
    usfl_rx_entry_type new_entry;
    usfl_rx_entry_type head_entry;

    assign nbits = `USFL_DATA_BITS + {3'h0, st.ctrl_a[`USFL_A_NINTH]};
    assign wb_rsp.ack = st.ack;
    assign wb_rsp.dat = st.rdata;
    assign tx_out = st.tx_line;
    assign tx_oe = st.ctrl_a[`USFL_A_ENABLE] & st.ctrl_b[`USFL_B_TX_EN];
    assign rx_irq = st.rx_full & st.ctrl_b[`USFL_B_RX_IRQ_EN];

    always_comb
    begin
        next_st = st;
        acc = wb_req.cyc & wb_req.stb & ~st.ack;
        rd = acc & ~wb_req.we;
        wr = acc & wb_req.we & wb_req.sel[0];
        data_acc = acc & (wb_req.adr == `USFL_ADR_DATA);
        word_done = 1'b0;
        pop = 1'b0;
        head_load = 1'b0;
        head_entry = st.buf0;
        bitval = 1'b0;
        rx_word = '0;
        new_entry = '0;
        // One cycle answer; unmapped offsets read zero and ignore writes.
        next_st.ack = acc;
        next_st.rdata = '0;
        if (rd)
        begin
            case (wb_req.adr)
                `USFL_ADR_STATUS: next_st.rdata[7:0] = {st.parity_error_flag, st.nf,
                    st.framing_error_flag, st.overrun_flag, st.receiver_idle_flag, st.rx_full, st.transmit_idle_flag,
                    st.tx_empty};
                `USFL_ADR_CTRL_A: next_st.rdata[7:0] = {st.ctrl_a[7:2],
                    st.buf0.data[8], 1'b0};
                `USFL_ADR_CTRL_B: next_st.rdata[7:0] = st.ctrl_b;
                `USFL_ADR_DATA: next_st.rdata[7:0] = st.buf0.data[7:0];
                `USFL_ADR_BAUD: next_st.rdata[7:0] = st.baud;
                default: next_st.rdata = '0;
            endcase
        end
        // The status offset has no write branch, so its flags stay put.
        if (wr)
        begin
            case (wb_req.adr)
                `USFL_ADR_CTRL_A: next_st.ctrl_a = {wb_req.dat[7:2],
                    st.ctrl_a[1], wb_req.dat[0]};
                `USFL_ADR_CTRL_B: next_st.ctrl_b = wb_req.dat[7:0];
                `USFL_ADR_BAUD: next_st.baud = wb_req.dat[7:0];
                default: next_st.baud = st.baud;
            endcase
        end
        tick = (st.baud_cnt == st.baud);
        next_st.baud_cnt = tick ? 8'h00 : st.baud_cnt + 8'h01;

        // Status read arms the clear; the next data access consumes it.
        if (rd && wb_req.adr == `USFL_ADR_STATUS)
        begin
            next_st.arm_err = 1'b1;
            next_st.arm_rx = st.rx_full;
        end
        if (data_acc)
        begin
            next_st.arm_err = 1'b0;
            next_st.arm_rx = 1'b0;
            if (st.arm_err)
            begin
                next_st.parity_error_flag = 1'b0;
                next_st.nf = 1'b0;
                next_st.framing_error_flag = 1'b0;
                next_st.overrun_flag = 1'b0;
            end
            pop = ~wb_req.we & st.arm_rx;
        end
        if (pop)
        begin
            if (st.rx_cnt == 2'h2)
            begin
                next_st.buf0 = st.buf1;
                next_st.rx_cnt = 2'h1;
                head_load = 1'b1;
                head_entry = st.buf1;
            end
            else
            begin
                next_st.rx_cnt = 2'h0;
                next_st.rx_full = 1'b0;
            end
        end

        // Receiver: three votes around the bit centre on each tick.
        bitval = (st.rx_votes[0] & st.rx_votes[1])
            | (rx_in & (st.rx_votes[0] | st.rx_votes[1]));
        if (st.rx_state == USFL_RX_IDLE)
        begin
            next_st.receiver_idle_flag = 1'b1;
            if (st.ctrl_b[`USFL_B_RX_EN] && !rx_in)
            begin
                next_st.rx_state = USFL_RX_START;
                next_st.rx_phase = 4'h0;
                next_st.rx_noise = 1'b0;
                next_st.rx_fe = 1'b0;
                next_st.receiver_idle_flag = 1'b0;
            end
        end
        else if (tick)
        begin
            next_st.rx_phase = st.rx_phase + 4'h1;
            if (st.rx_phase == `USFL_VOTE_A)
                next_st.rx_votes[0] = rx_in;
            if (st.rx_phase == `USFL_VOTE_B)
                next_st.rx_votes[1] = rx_in;
            if (st.rx_phase == `USFL_VOTE_C && st.rx_votes != {2{rx_in}})
                next_st.rx_noise = 1'b1;
            case (st.rx_state)
                USFL_RX_START:
                begin
                    if (st.rx_phase == `USFL_VOTE_C && bitval)
                        next_st.rx_state = USFL_RX_IDLE;
                    if (st.rx_phase == `USFL_PHASE_LAST)
                    begin
                        next_st.rx_state = USFL_RX_DATA;
                        next_st.rx_bitn = 4'h0;
                    end
                end
                USFL_RX_DATA:
                begin
                    if (st.rx_phase == `USFL_VOTE_C)
                    begin
                        next_st.rx_shift = {bitval, st.rx_shift[8:1]};
                        next_st.rx_bitn = st.rx_bitn + 4'h1;
                    end
                    if (st.rx_phase == `USFL_PHASE_LAST && st.rx_bitn == nbits)
                        next_st.rx_state = USFL_RX_STOP;
                end
                USFL_RX_STOP:
                begin
                    if (st.rx_phase == `USFL_VOTE_C)
                        next_st.rx_fe = ~bitval;
                    if (st.rx_phase == `USFL_PHASE_LAST)
                    begin
                        next_st.rx_state = USFL_RX_IDLE;
                        word_done = 1'b1;
                    end
                end
                default: next_st.rx_state = USFL_RX_IDLE;
            endcase
        end
        rx_word = st.ctrl_a[`USFL_A_NINTH] ? st.rx_shift
            : {1'b0, st.rx_shift[8:1]};
        new_entry.data = rx_word;
        new_entry.nf = st.rx_noise;
        new_entry.fe = st.rx_fe;
        new_entry.pe = st.ctrl_a[`USFL_A_PAR_EN]
            & ((^rx_word) != st.ctrl_a[`USFL_A_PAR_ODD]);
        // A full buffer or a standing overrun discards the new word.
        if (word_done && !st.overrun_flag)
        begin
            if (next_st.rx_cnt == 2'h2)
                next_st.overrun_flag = 1'b1;
            else if (next_st.rx_cnt == 2'h1)
            begin
                next_st.buf1 = new_entry;
                next_st.rx_cnt = 2'h2;
            end
            else
            begin
                next_st.buf0 = new_entry;
                next_st.rx_cnt = 2'h1;
                head_load = 1'b1;
                head_entry = new_entry;
            end
        end
        // Flags of a word land with its move into the data register.
        if (head_load)
        begin
            next_st.rx_full = 1'b1;
            next_st.nf = next_st.nf | head_entry.nf;
            next_st.framing_error_flag = next_st.framing_error_flag | head_entry.fe;
            next_st.parity_error_flag = next_st.parity_error_flag | head_entry.pe;
        end

        // Transmitter.
        tx_word = st.tx_hold;
        if (!st.ctrl_a[`USFL_A_NINTH])
            tx_word[8] = 1'b0;
        tx_par = (st.ctrl_a[`USFL_A_NINTH] ? ^tx_word[7:0] : ^tx_word[6:0])
            ^ st.ctrl_a[`USFL_A_PAR_ODD];
        if (st.ctrl_a[`USFL_A_PAR_EN] && st.ctrl_a[`USFL_A_NINTH])
            tx_word[8] = tx_par;
        else if (st.ctrl_a[`USFL_A_PAR_EN])
            tx_word[7] = tx_par;
        if (wr && wb_req.adr == `USFL_ADR_DATA
            && st.ctrl_b[`USFL_B_TX_EN])
        begin
            next_st.tx_hold = {st.ctrl_a[`USFL_A_TX8], wb_req.dat[7:0]};
            next_st.tx_empty = 1'b0;
        end
        case (st.tx_state)
            USFL_TX_IDLE:
            begin
                next_st.tx_line = 1'b1;
                if (!st.tx_empty)
                begin
                    next_st.tx_shift = tx_word;
                    next_st.tx_empty = 1'b1;
                    next_st.tx_state = USFL_TX_START;
                    next_st.tx_phase = 4'h0;
                    next_st.tx_line = 1'b0;
                end
                else if (st.ctrl_a[`USFL_A_BREAK])
                begin
                    next_st.tx_state = USFL_TX_BREAK;
                    next_st.brk_cnt = 8'h00;
                    next_st.tx_line = 1'b0;
                end
            end
            USFL_TX_START:
            begin
                if (tick)
                    next_st.tx_phase = st.tx_phase + 4'h1;
                if (tick && st.tx_phase == `USFL_PHASE_LAST)
                begin
                    next_st.tx_state = USFL_TX_DATA;
                    next_st.tx_bitn = 4'h0;
                    next_st.tx_line = st.tx_shift[0];
                end
            end
            USFL_TX_DATA:
            begin
                if (tick)
                    next_st.tx_phase = st.tx_phase + 4'h1;
                if (tick && st.tx_phase == `USFL_PHASE_LAST)
                begin
                    next_st.tx_shift = {1'b0, st.tx_shift[8:1]};
                    next_st.tx_bitn = st.tx_bitn + 4'h1;
                    next_st.tx_line = st.tx_shift[1];
                    if (st.tx_bitn + 4'h1 == nbits)
                    begin
                        next_st.tx_state = USFL_TX_STOP;
                        next_st.tx_bitn = 4'h0;
                        next_st.tx_line = 1'b1;
                    end
                end
            end
            USFL_TX_STOP:
            begin
                next_st.tx_line = 1'b1;
                if (tick)
                    next_st.tx_phase = st.tx_phase + 4'h1;
                if (tick && st.tx_phase == `USFL_PHASE_LAST)
                begin
                    next_st.tx_bitn = st.tx_bitn + 4'h1;
                    if (st.tx_bitn[0] == st.ctrl_a[`USFL_A_TWO_STOP])
                        next_st.tx_state = USFL_TX_IDLE;
                end
            end
            USFL_TX_BREAK:
            begin
                next_st.tx_line = 1'b0;
                if (tick && st.brk_cnt != 8'(`USFL_BREAK_TICKS))
                    next_st.brk_cnt = st.brk_cnt + 8'h01;
                if (st.brk_cnt == 8'(`USFL_BREAK_TICKS)
                    && !st.ctrl_a[`USFL_A_BREAK])
                begin
                    next_st.tx_state = USFL_TX_IDLE;
                    next_st.tx_line = 1'b1;
                end
            end
            default: next_st.tx_state = USFL_TX_IDLE;
        endcase
        // A dropped transmitter enable aborts and empties the holding stage.
        if (!next_st.ctrl_b[`USFL_B_TX_EN])
        begin
            next_st.tx_empty = 1'b1;
            next_st.tx_state = USFL_TX_IDLE;
            next_st.tx_line = 1'b1;
        end
        if (!next_st.ctrl_b[`USFL_B_RX_EN])
        begin
            next_st.rx_state = USFL_RX_IDLE;
            next_st.receiver_idle_flag = 1'b1;
        end
        if (!next_st.ctrl_a[`USFL_A_ENABLE])
        begin
            next_st.ctrl_b[`USFL_B_TX_EN] = 1'b0;
            next_st.ctrl_b[`USFL_B_RX_EN] = 1'b0;
            next_st.ctrl_a[`USFL_A_BREAK] = 1'b0;
            next_st.baud_cnt = 8'h00;
            next_st.parity_error_flag = 1'b0;
            next_st.nf = 1'b0;
            next_st.framing_error_flag = 1'b0;
            next_st.overrun_flag = 1'b0;
            next_st.rx_full = 1'b0;
            next_st.rx_cnt = 2'h0;
            next_st.receiver_idle_flag = 1'b1;
            next_st.tx_empty = 1'b1;
            next_st.rx_state = USFL_RX_IDLE;
            next_st.tx_state = USFL_TX_IDLE;
            next_st.tx_line = 1'b1;
        end
        next_st.transmit_idle_flag = next_st.tx_empty & ~next_st.ctrl_a[`USFL_A_BREAK]
            & (next_st.tx_state == USFL_TX_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st <= '0;
            {st.parity_error_flag, st.nf, st.framing_error_flag, st.overrun_flag, st.receiver_idle_flag, st.rx_full,
                st.transmit_idle_flag, st.tx_empty} <= `USFL_STATUS_RST;
            st.ctrl_a <= `USFL_CTRL_RST;
            st.ctrl_b <= `USFL_CTRL_RST;
            st.baud <= `USFL_BAUD_RST;
            st.tx_line <= 1'b1;
            st.rx_state <= USFL_RX_IDLE;
            st.tx_state <= USFL_TX_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_PARITY_ERROR_FLAG_NEEDS_PARITY: assert property (
        $rose(st.parity_error_flag) |-> st.ctrl_a[`USFL_A_PAR_EN])
        else $error("Parity error flag rose with parity off.");
    AST_NOISE_WITH_FULL: assert property (
        $rose(st.nf) |-> st.rx_full && !$rose(st.overrun_flag))
        else $error("Noise flag rose without receive-full.");
    AST_ERR_CLEAR_SEQ: assert property (
        data_acc && st.arm_err && !head_load |=> !st.parity_error_flag && !st.framing_error_flag)
        else $error("Error flags survived the clearing sequence.");
    AST_OVERRUN_BLOCKS: assert property (
        st.overrun_flag && word_done && !pop |=> $stable(st.rx_cnt))
        else $error("Word stored while overrun was set.");
    AST_OVERRUN_STICKY: assert property (
        st.overrun_flag && !(data_acc && st.arm_err) && st.ctrl_a[`USFL_A_ENABLE]
        ##1 st.ctrl_a[`USFL_A_ENABLE] |-> st.overrun_flag)
        else $error("Overrun flag cleared without the sequence.");
    AST_RECEIVER_IDLE_FLAG_LOW_BUSY: assert property (
        st.rx_state != USFL_RX_IDLE |-> !st.receiver_idle_flag)
        else $error("Receiver idle high during a frame.");
    AST_TRANSMIT_IDLE_FLAG_LINE_HIGH: assert property (
        st.transmit_idle_flag |-> tx_out)
        else $error("Transmit line low while idle.");
    AST_TRANSMIT_IDLE_FLAG_QUEUED: assert property (
        !st.tx_empty || st.tx_state == USFL_TX_BREAK |-> !st.transmit_idle_flag)
        else $error("Transmit idle set with work queued.");
    AST_EMPTY_ON_TAKE: assert property (
        st.tx_state == USFL_TX_IDLE && !st.tx_empty
        |=> st.tx_empty || !st.ctrl_b[`USFL_B_TX_EN]
            || $past(wr && wb_req.adr == `USFL_ADR_DATA))
        else $error("Transmit-empty not set when shifter took data.");
    AST_DISABLE_FLAGS: assert property (
        !st.ctrl_a[`USFL_A_ENABLE] |-> st.receiver_idle_flag && st.transmit_idle_flag && st.tx_empty
        && !st.rx_full && !st.overrun_flag ##1 st.ctrl_a[`USFL_A_ENABLE] || st.receiver_idle_flag)
        else $error("Disabled port flags not at their rest values.");
    AST_ACK_ONE_CYCLE: assert property (
        st.ack |=> !st.ack)
        else $error("Bus answer held for more than one cycle.");

    COV_WORD_RECEIVED: cover property ($rose(st.rx_full));
    COV_OVERRUN: cover property ($rose(st.overrun_flag));
    COV_BREAK: cover property (st.tx_state == USFL_TX_BREAK ##1
        st.tx_state == USFL_TX_IDLE);
    COV_FRAME_SENT: cover property ($rose(st.transmit_idle_flag));
endmodule // usfl_top

// ==== shared/usfl_map.svh ====
// Register offsets, field positions, reset values and timing counts.
// Operation
// - Parity error flag, status bit 7, set on bad parity when parity enabled.
// - Parity error flag clears on status read then data register access.
// - Noise flag, status bit 6, rises with receive-full, never on overrun.
// - Noise flag clears on status read then data register access.
// - Framing error flag, status bit 5, sets on bad stop; same clearing.
// - Overrun flag, bit 4, sets on buffer overflow; blocks further transfers.
// - Overrun flag clears only on status read then data register access, or on port disable.
// - Receiver idle flag, bit 3, low from start detection to stop completion.
// - Receiver idle flag high from stop completion until next start detected.
// - Receive-full flag, bit 2, sets on word transfer; irq if enabled.
// - Noise, framing, parity flags set in the same cycle as receive-full.
// - Receive-full clears on flagged status read, data read, buffer empty.
// - Transmit idle flag, bit 1, set when empty and nothing being sent.
// - Transmit output held high whenever transmit idle flag is set.
// - Transmit idle clears on a data register write with the transmitter enabled.
// - Transmit idle stays low while data or break is queued.
// - Transmit-empty flag, bit 0, sets when shifter takes a character.
// - Transmit-empty clears on a data register write with the transmitter enabled.
// - Transmit-empty is held set while the transmitter is disabled.
// - Status flags are read only; writes to status are ignored.
// - Data shifts least significant bit first at baud generator rate.
// - Break holds output low at least 13 bit times, until request withdrawn.
// - Disabling port clears errors, receive-full; sets idles and empty.
`ifndef USFL_MAP_SVH
`define USFL_MAP_SVH
`define USFL_ADR_STATUS 8'h00
`define USFL_ADR_CTRL_A 8'h04
`define USFL_ADR_CTRL_B 8'h08
`define USFL_ADR_DATA 8'h0c
`define USFL_ADR_BAUD 8'h10
`define USFL_A_ENABLE 7
`define USFL_A_NINTH 6
`define USFL_A_PAR_EN 5
`define USFL_A_PAR_ODD 4
`define USFL_A_TWO_STOP 3
`define USFL_A_BREAK 2
`define USFL_A_RX8 1
`define USFL_A_TX8 0
`define USFL_B_TX_EN 7
`define USFL_B_RX_EN 6
`define USFL_B_RX_IRQ_EN 2
`define USFL_STATUS_RST 8'h0b
`define USFL_CTRL_RST 8'h00
`define USFL_BAUD_RST 8'h00
`define USFL_DATA_BITS 4'h8
`define USFL_VOTE_A 4'h7
`define USFL_VOTE_B 4'h8
`define USFL_VOTE_C 4'h9
`define USFL_PHASE_LAST 4'hf
`define USFL_BREAK_BITS 13
`define USFL_OVERSAMPLE 16
`define USFL_BREAK_TICKS (`USFL_BREAK_BITS * `USFL_OVERSAMPLE)
`endif

// ==== shared/usfl_pkg.sv ====
// Types shared by the serial port status logic.
package usfl_pkg;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } usfl_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } usfl_wb_rsp_type;

    typedef enum logic [1:0] {
        USFL_RX_IDLE = 2'b00,
        USFL_RX_START = 2'b01,
        USFL_RX_DATA = 2'b11,
        USFL_RX_STOP = 2'b10
    } usfl_rx_state_type;

    typedef enum logic [2:0] {
        USFL_TX_IDLE = 3'b000,
        USFL_TX_START = 3'b001,
        USFL_TX_DATA = 3'b011,
        USFL_TX_STOP = 3'b010,
        USFL_TX_BREAK = 3'b110
    } usfl_tx_state_type;

    typedef struct packed {
        logic nf;
        logic fe;
        logic pe;
        logic [8:0] data;
    } usfl_rx_entry_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] baud;
        logic [7:0] baud_cnt;
        logic parity_error_flag;
        logic nf;
        logic framing_error_flag;
        logic overrun_flag;
        logic receiver_idle_flag;
        logic rx_full;
        logic transmit_idle_flag;
        logic tx_empty;
        logic arm_err;
        logic arm_rx;
        usfl_rx_entry_type buf0;
        usfl_rx_entry_type buf1;
        logic [1:0] rx_cnt;
        usfl_rx_state_type rx_state;
        logic [3:0] rx_phase;
        logic [3:0] rx_bitn;
        logic [8:0] rx_shift;
        logic [1:0] rx_votes;
        logic rx_noise;
        logic rx_fe;
        usfl_tx_state_type tx_state;
        logic [3:0] tx_phase;
        logic [3:0] tx_bitn;
        logic [8:0] tx_shift;
        logic [8:0] tx_hold;
        logic [7:0] brk_cnt;
        logic tx_line;
    } usfl_state_type;
endpackage

// ==== bench/usfl_serial_peer.sv ====
// Remote serial device: sends frames into the port and listens to it.
`timescale 1ns/100ps
module usfl_serial_peer
(
    input wire logic clk,
    input wire logic go,
    input wire logic [9:0] frame,
    input wire logic bad_stop,
    input wire logic glitch,
    input wire logic tx_line,
    output logic line,
    output logic busy,
    output logic [7:0] heard
);
    int n = 0;
    int m = 0;
    logic [9:0] sh = '1;
    initial heard = 8'h00;
    assign busy = (n != 0);
    always @(posedge clk)
    begin
        if (go && n == 0)
            sh <= frame;
        n <= (go && n == 0) ? 160 : (n != 0) ? n - 1 : 0;
        m <= (m == 0) ? int'(!tx_line) : (m == 152) ? 0 : m + 1;
        // Bit centres arrive lowest bit first.
        if (m % 16 == 8 && m > 16 && m < 144)
            heard <= {tx_line, heard[7:1]};
    end
    // A broken stop bit stays low past the port's vote window.
    always_comb
    begin
        line = 1'b1;
        if (n != 0)
            line = sh[(160 - n) / 16] ^ (glitch && n == 135);
        if (bad_stop && n > 4 && n <= 16)
            line = 1'b0;
    end
endmodule // usfl_serial_peer

// ==== bench/tb_top.sv ====
// Self-checking bench for the serial port status flags.
`timescale 1ns/100ps
`include "usfl_map.svh"
module tb_top;
    import usfl_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    usfl_wb_req_type wb_req = '0;
    usfl_wb_rsp_type wb_rsp;
    logic rx_in, tx_out, tx_oe, rx_irq, busy;
    logic go = 1'b0;
    logic [9:0] frame = '1;
    logic bad_stop = 1'b0;
    logic glitch = 1'b0;
    logic [7:0] heard;
    logic [7:0] s;
    int fail_count = 0;
    int n_checks = 0;
    always #50 clk = ~clk;
    usfl_top usfl_top_inst (.clk(clk), .reset(reset), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe),
        .rx_irq(rx_irq));
    // A released transmit pin is pulled high.
    usfl_serial_peer usfl_serial_peer_inst (.clk(clk), .go(go),
        .frame(frame), .bad_stop(bad_stop), .glitch(glitch),
        .tx_line(tx_oe ? tx_out : 1'b1), .line(rx_in), .busy(busy),
        .heard(heard));
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string w, input logic [7:0] e, x);
        n_checks++;
        if (x !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", w, e, x);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, d);
        int k;
        wb_req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
        for (k = 0; k < 20 && wb_rsp.ack !== 1'b1; k++)
            @(posedge clk);
        check("ack", 8'h01, {7'h0, wb_rsp.ack});
        if (k == 20)
            conclude();
        s = wb_rsp.dat[7:0];
        wb_req <= '0;
        @(posedge clk);
    endtask
    task automatic st(input logic [7:0] e);
        wb(1'b0, `USFL_ADR_STATUS, 8'h00);
        check("status", e, s);
    endtask
    task automatic dt(input logic [7:0] e);
        wb(1'b0, `USFL_ADR_DATA, 8'h00);
        check("data", e, s);
    endtask
    task automatic send(input logic [7:0] d, input logic bs, gl);
        int k;
        go <= 1'b1;
        frame <= {1'b1, d, 1'b0};
        bad_stop <= bs;
        glitch <= gl;
        @(posedge clk);
        go <= 1'b0;
        repeat (40) @(posedge clk);
        wb(1'b0, `USFL_ADR_STATUS, 8'h00);
        check("receiver idle", 8'h00, {7'h0, s[3]});
        for (k = 0; k < 200 && busy; k++)
            @(posedge clk);
        check("peer busy", 8'h00, {7'h0, busy});
        if (k == 200)
            conclude();
        repeat (24) @(posedge clk);
    endtask
    task automatic t_reset();
        st(8'h0b);
        wb(1'b1, `USFL_ADR_STATUS, 8'hf4);
        st(8'h0b);
        wb(1'b0, 8'h20, 8'h00);
        check("unmapped", 8'h00, s);
        $display("test reset done");
    endtask
    task automatic t_tx();
        wb(1'b1, `USFL_ADR_CTRL_A, 8'h80);
        wb(1'b1, `USFL_ADR_CTRL_B, 8'hc4);
        st(8'h0b);
        wb(1'b1, `USFL_ADR_DATA, 8'ha5);
        wb(1'b1, `USFL_ADR_DATA, 8'h5a);
        st(8'h08);
        repeat (165) @(posedge clk);
        check("first byte", 8'ha5, heard);
        st(8'h09);
        repeat (200) @(posedge clk);
        check("second byte", 8'h5a, heard);
        st(8'h0b);
        check("tx idle level", 8'h01, {7'h0, tx_out});
        check("tx enable", 8'h01, {7'h0, tx_oe});
        // Even parity in bit 7 and two stop bits.
        wb(1'b1, `USFL_ADR_CTRL_A, 8'ha8);
        wb(1'b1, `USFL_ADR_DATA, 8'h01);
        repeat (165) @(posedge clk);
        st(8'h09);
        repeat (20) @(posedge clk);
        check("parity byte", 8'h81, heard);
        st(8'h0b);
        wb(1'b1, `USFL_ADR_CTRL_A, 8'h80);
        $display("test transmit done");
    endtask
    task automatic t_rx();
        send(8'h3c, 1'b0, 1'b0);
        st(8'h0f);
        check("irq", 8'h01, {7'h0, rx_irq});
        dt(8'h3c);
        st(8'h0b);
        check("irq", 8'h00, {7'h0, rx_irq});
        $display("test receive done");
    endtask
    task automatic t_errors();
        // Control A, data, broken stop, glitch, status expected.
        logic [25:0] tb[6] = '{{8'h80, 8'h3c, 2'b10, 8'h2f},
            {8'h80, 8'h3c, 2'b01, 8'h4f}, {8'ha0, 8'h01, 2'b00, 8'h8f},
            {8'ha0, 8'h03, 2'b00, 8'h0f}, {8'hb0, 8'h01, 2'b00, 8'h0f},
            {8'hb0, 8'h03, 2'b00, 8'h8f}};
        foreach (tb[i])
        begin
            wb(1'b1, `USFL_ADR_CTRL_A, tb[i][25:18]);
            send(tb[i][17:10], tb[i][9], tb[i][8]);
            st(tb[i][7:0]);
            wb(1'b0, `USFL_ADR_DATA, 8'h00);
            check("data", tb[i][16:10], s[6:0]);
            st(8'h0b);
        end
        wb(1'b1, `USFL_ADR_CTRL_A, 8'h80);
        $display("test errors done");
    endtask
    task automatic t_overrun();
        send(8'h11, 1'b0, 1'b0);
        send(8'h22, 1'b0, 1'b0);
        send(8'h33, 1'b0, 1'b0);
        send(8'h44, 1'b0, 1'b0);
        st(8'h1f);
        dt(8'h11);
        st(8'h0f);
        dt(8'h22);
        st(8'h0b);
        $display("test overrun done");
    endtask
    task automatic t_break();
        wb(1'b1, `USFL_ADR_CTRL_A, 8'h84);
        wb(1'b1, `USFL_ADR_CTRL_A, 8'h80);
        st(8'h09);
        repeat (201) @(posedge clk);
        check("break level", 8'h00, {7'h0, tx_out});
        repeat (9) @(posedge clk);
        check("break end", 8'h01, {7'h0, tx_out});
        st(8'h0b);
        $display("test break done");
    endtask
    task automatic t_disable();
        send(8'h3c, 1'b1, 1'b0);
        wb(1'b1, `USFL_ADR_CTRL_A, 8'h00);
        st(8'h0b);
        check("tx enable", 8'h00, {7'h0, tx_oe});
        wb(1'b0, `USFL_ADR_CTRL_B, 8'h00);
        check("control b", 8'h04, s);
        $display("test disable done");
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_tx();
        t_rx();
        t_errors();
        t_overrun();
        t_break();
        t_disable();
        conclude();
    end
endmodule // tb_top
